// ==== verilog/icr_top.sv ====
// interrupt control two register with edge select and event status
//
// Contract
// - vector select one picks alternate table
// - disable status bit read-only, shows timed disable
// - bit 4 sets ext irq4 edge
// - bit 3 sets ext irq3 edge
// - bits 2..0 set ext irq2..0 edges
// - bits 13..5 read zero, writes ignored
`timescale 1ns/10ps
module icr_top (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [icr_pkg::ICR_ADDR_W-1:0] addr_in,
  input wire logic [icr_pkg::ICR_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [icr_pkg::ICR_DATA_W-1:0] rdata_out,
  input wire logic timed_irq_disable_active_in,
  input wire logic [icr_pkg::ICR_NUM_EXT-1:0] ext_irq_in,
  output logic alternate_vector_select_out,
  output logic [icr_pkg::ICR_NUM_EXT-1:0] ext_irq_edge_out,
  output logic irq_out
);
  import icr_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  icr_bus_s bus;
  icr_cfg_s cfg_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [4:0] status_q;
  logic [4:0] mask_q;
  logic [4:0] edge_hit;
  logic [15:0] ctrl2_view;
  logic ctrl_wr;
  logic [15:0] ctrl_wdata;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign ctrl_wr = bus.wr && (bus.addr == ICR_OFS_CTRL2);
  assign ctrl_wdata = bus.wdata & ICR_CTRL2_WMASK;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_q.alt_vector_select <= ICR_CTRL2_RST[ICR_ALTVT_BIT];
      cfg_q.edge_polarity <= ICR_CTRL2_RST[ICR_EP_LSB +: 5];
    end else if (ctrl_wr) begin
      cfg_q.alt_vector_select <= ctrl_wdata[ICR_ALTVT_BIT];
      cfg_q.edge_polarity <= ctrl_wdata[ICR_EP_LSB +: 5];
    end
  end

  // disable status is a live view, never stored from writes
  always_comb begin
    ctrl2_view = ICR_CTRL2_RST;
    ctrl2_view[ICR_ALTVT_BIT] = cfg_q.alt_vector_select;
    ctrl2_view[ICR_TIMED_IRQ_DISABLE_ACTIVE_BIT] = timed_irq_disable_active_in;
    ctrl2_view[ICR_EP_LSB +: 5] = cfg_q.edge_polarity;
  end

  // ****************************************
  // edge detectors
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_ext
      icr_edge_det u_det (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(ext_irq_in[gi]),
        .falling_sel_in(cfg_q.edge_polarity[gi]),
        .edge_out(edge_hit[gi])
      );
    end
  endgenerate

  assign ext_irq_edge_out = edge_hit;
  assign alternate_vector_select_out = cfg_q.alt_vector_select;

  // ****************************************
  // status and mask
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_q <= ICR_STATUS_RST;
    end else begin
      // set wins over write-one-to-clear
      if (bus.wr && (bus.addr == ICR_OFS_STATUS)) begin
        status_q <= (status_q & ~bus.wdata[4:0]) | edge_hit;
      end else begin
        status_q <= status_q | edge_hit;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mask_q <= ICR_MASK_RST;
    end else if (bus.wr && (bus.addr == ICR_OFS_MASK)) begin
      mask_q <= bus.wdata[4:0];
    end
  end

  assign irq_out = |(status_q & mask_q);

  // ****************************************
  // read port
  // ****************************************
  always_comb begin
    rdata_d = ICR_ZERO;
    case (bus.addr)
      ICR_OFS_CTRL2: rdata_d = ctrl2_view;
      ICR_OFS_STATUS: rdata_d = {11'h000, status_q};
      ICR_OFS_MASK: rdata_d = {11'h000, mask_q};
      default: rdata_d = ICR_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= ICR_ZERO;
    end else if (bus.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= ICR_ZERO;
    end
  end

  // zero outside the read slot
  assign rdata_out = rdata_q;

  // ****************************************
  // checks: register port
  // ****************************************
  alt_vec_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ctrl_wr |=> alternate_vector_select_out == $past(wdata_in[15]))
    else $error("alternate vector select not taken from write");

  ctrl_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !ctrl_wr |=> $stable(cfg_q))
    else $error("control bits changed without a write");

  timed_irq_disable_active_readback_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (rd_in && addr_in == ICR_OFS_CTRL2) |=> rdata_out[14] == $past(timed_irq_disable_active_in))
    else $error("disable status readback wrong");

  timed_irq_disable_active_no_store_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (rd_in && addr_in == ICR_OFS_CTRL2 && !timed_irq_disable_active_in) |=> !rdata_out[14])
    else $error("disable status stored from write");

  unimpl_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $past(rd_in && addr_in == ICR_OFS_CTRL2) |-> rdata_out[13:5] == 9'h000)
    else $error("unimplemented bits not zero");

  unmapped_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $past(rd_in && addr_in > ICR_OFS_MASK) |-> rdata_out == ICR_ZERO)
    else $error("unmapped index read not zero");

  read_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !rd_in |=> rdata_out == 16'h0000)
    else $error("read data outside read slot");

  // ****************************************
  // checks: edge select
  // ****************************************
  irq4_fall_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (cfg_q.edge_polarity[4] && $fell(ext_irq_in[4])) |-> ext_irq_edge_out[4])
    else $error("irq4 falling edge missed");

  irq3_rise_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (!cfg_q.edge_polarity[3] && $rose(ext_irq_in[3])) |-> ext_irq_edge_out[3])
    else $error("irq3 rising edge missed");

  irq0_wrong_edge_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (!cfg_q.edge_polarity[0] && $fell(ext_irq_in[0])) |-> !ext_irq_edge_out[0])
    else $error("irq0 fired on wrong edge");

  // pin history is low for one cycle after reset, so skip that cycle
  genvar gc;
  generate
    for (gc = 0; gc < 5; gc++) begin : g_edge_chk
      edge_sel_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $past(rst_b_in) |-> ext_irq_edge_out[gc] ==
          (cfg_q.edge_polarity[gc] ? $fell(ext_irq_in[gc]) : $rose(ext_irq_in[gc])))
        else $error("edge output disagrees with polarity");
    end
  endgenerate

  // ****************************************
  // checks: status and interrupt
  // ****************************************
  status_sticky_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    |edge_hit |=> (status_q & $past(edge_hit)) == $past(edge_hit))
    else $error("event not recorded in status");

  status_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (wr_in && addr_in == ICR_OFS_STATUS && edge_hit == 5'h00) |=>
      (status_q & $past(wdata_in[4:0])) == 5'h00)
    else $error("status bit not cleared by write of one");

  mask_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (wr_in && addr_in == ICR_OFS_MASK) |=> mask_q == $past(wdata_in[4:0]))
    else $error("mask not taken from write");

  irq_follow_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ((|(edge_hit & mask_q)) && !wr_in) |=> irq_out)
    else $error("unmasked event did not raise the interrupt");

  // ****************************************
  // checks: reset
  // ****************************************
  reset_clear_a: assert property (@(posedge ref_clk_in)
    !rst_b_in |=> !alternate_vector_select_out && cfg_q.edge_polarity == 5'h00 &&
      rdata_out == ICR_ZERO && !irq_out)
    else $error("outputs not cleared by reset");
endmodule : icr_top

// ==== verilog/icr_pkg.sv ====
// package for the interrupt control two register block
package icr_pkg;
  localparam int unsigned ICR_ADDR_W = 4;
  localparam int unsigned ICR_DATA_W = 16;
  localparam int unsigned ICR_NUM_EXT = 5;
  // register offsets (word index)
  localparam logic [3:0] ICR_OFS_CTRL2 = 4'h0;
  localparam logic [3:0] ICR_OFS_STATUS = 4'h1;
  localparam logic [3:0] ICR_OFS_MASK = 4'h2;
  // field positions of interrupt_control_two
  localparam int unsigned ICR_ALTVT_BIT = 15;
  localparam int unsigned ICR_TIMED_IRQ_DISABLE_ACTIVE_BIT = 14;
  localparam int unsigned ICR_EP_LSB = 0;
  localparam logic [15:0] ICR_CTRL2_WMASK = 16'h801f;
  // reset values
  localparam logic [15:0] ICR_CTRL2_RST = 16'h0000;
  localparam logic [4:0] ICR_STATUS_RST = 5'h00;
  localparam logic [4:0] ICR_MASK_RST = 5'h00;
  localparam logic [15:0] ICR_ZERO = 16'h0000;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } icr_bus_s;

  typedef struct packed {
    logic alt_vector_select;
    logic [4:0] edge_polarity;
  } icr_cfg_s;
endpackage : icr_pkg

// ==== verilog/icr_edge_det.sv ====
// one external interrupt edge detector with selectable polarity
`timescale 1ns/10ps
module icr_edge_det (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  input wire logic falling_sel_in,
  output logic edge_out
);
  import icr_pkg::*;
  logic pin_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_in;
    end
  end

  // one selects falling, zero rising
  assign edge_out = falling_sel_in ? (pin_q & ~pin_in) : (~pin_q & pin_in);
endmodule : icr_edge_det

// ==== tb/icr_pin_model.sv ====
// model of the external interrupt pins and the timed disable source
`timescale 1ns/10ps
module icr_pin_model (
  input wire logic ref_clk_in,
  input wire logic [4:0] level_in,
  input wire logic dis_in,
  output logic [4:0] pins_out,
  output logic dis_out
);
  initial begin
    pins_out = 5'h00;
    dis_out = 1'b0;
  end
  // pins move only just after a core clock edge
  always @(posedge ref_clk_in) begin
    pins_out <= level_in;
    dis_out <= dis_in;
  end
endmodule : icr_pin_model

// ==== tb/tb_top.sv ====
// self-checking bench for the interrupt control two register block
`timescale 1ns/10ps
module tb_top;
  import icr_pkg::*;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, dis = 0, pdis, alt, irq;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, d;
  logic [4:0] lvl = 5'h00, pins, edg, p, m;
  int bad_count = 0, n_tests = 0;
  icr_pin_model i_pins (.ref_clk_in(clk), .level_in(lvl), .dis_in(dis), .pins_out(pins),
    .dis_out(pdis));
  icr_top i_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .timed_irq_disable_active_in(pdis),
    .ext_irq_in(pins), .alternate_vector_select_out(alt), .ext_irq_edge_out(edg),
    .irq_out(irq));
  // ********************************
  // bus and compare helpers
  // ********************************
  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_reg
  function automatic logic [15:0] exp_ctrl(input logic [15:0] v, input logic s);
    return {v[15], s, 9'h000, v[4:0]};
  endfunction : exp_ctrl
  // ********************************
  // stimulus
  // ********************************
  initial forever #2 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(72887));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(ICR_OFS_CTRL2, 16'h0000);
    chk({15'h0000, alt}, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 16'hffff : 16'($urandom);
      dis <= ~d[14];
      wr_reg(ICR_OFS_CTRL2, d);
      chk({15'h0000, alt}, {15'h0000, d[15]});
      rd_reg(ICR_OFS_CTRL2, exp_ctrl(d, ~d[14]));
    end
    for (int a = 3; a < 16; a++) begin
      wr_reg(4'(a), 16'hffff);
      rd_reg(4'(a), 16'h0000);
    end
    for (int i = 0; i < 10; i++) begin
      p = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
      m = (i == 2) ? 5'h00 : 5'($urandom);
      wr_reg(ICR_OFS_CTRL2, {11'h000, p});
      lvl <= p;
      repeat (3) @(posedge clk);
      wr_reg(ICR_OFS_STATUS, 16'h001f);
      wr_reg(ICR_OFS_MASK, {11'h000, m});
      rd_reg(ICR_OFS_MASK, {11'h000, m});
      chk({15'h0000, irq}, 16'h0000);
      @(posedge clk) lvl <= ~p;
      @(posedge clk) #1 chk({11'h000, edg}, 16'h001f);
      @(posedge clk) lvl <= p;
      @(posedge clk) #1 chk({11'h000, edg}, 16'h0000);
      rd_reg(ICR_OFS_STATUS, 16'h001f);
      chk({15'h0000, irq}, {15'h0000, |m});
      wr_reg(ICR_OFS_STATUS, 16'h001f);
      chk({15'h0000, irq}, 16'h0000);
    end
    // event in the same cycle as its clear: the set wins
    lvl <= ~p;
    wr_reg(ICR_OFS_STATUS, 16'h001f);
    rd_reg(ICR_OFS_STATUS, 16'h001f);
    // reset in mid-run over a configured block
    lvl <= 5'h00;
    dis <= 1'b0;
    wr_reg(ICR_OFS_CTRL2, 16'hffff);
    wr_reg(ICR_OFS_MASK, 16'h001f);
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(ICR_OFS_CTRL2, 16'h0000);
    chk({15'h0000, alt}, 16'h0000);
    rd_reg(ICR_OFS_MASK, 16'h0000);
    rd_reg(ICR_OFS_STATUS, 16'h0000);
    give_verdict();
  end
endmodule : tb_top
